// >>> rtl/lcd_drive_pkg.sv
package lcd_drive_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the plain register port)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W               = 16;
    localparam int unsigned DATA_W               = 8;
    localparam logic [15:0] MAIN_CTRL_ADDR       = 16'h2400; // enable, multiplex, all-common, blink rate, divider
    localparam logic [15:0] SUPPLY_BLINK_B_ADDR  = 16'h2401; // supply mode, blink mask b
    localparam logic [15:0] BATTERY_BLINK_A_ADDR = 16'h2402; // battery select, blink mask a
    localparam logic [15:0] OVERRIDE_CTRL_ADDR   = 16'h240c; // force on, force off, data clear
    localparam logic [15:0] CONTRAST_DAC_ADDR    = 16'h240d; // contrast code
    localparam logic [15:0] SEQ_STATUS_ADDR      = 16'h2410; // read-only sequencer state
    localparam logic [7:0]  REG_RESET            = 8'h00;
    localparam logic [7:0]  BATTERY_MASK         = 8'hbf;    // bit 6 reserved, reads zero
    localparam logic [7:0]  OVERRIDE_MASK        = 8'h03;    // clear bit is not stored
    localparam logic [7:0]  CONTRAST_MASK        = 8'h1f;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned ENABLE_BIT     = 7;
    localparam int unsigned MUX_LSB        = 4;
    localparam int unsigned ALLCOM_BIT     = 3;
    localparam int unsigned BLINK_RATE_BIT = 2;
    localparam int unsigned CLKDIV_LSB     = 0;
    localparam int unsigned VMODE_LSB      = 6;
    localparam int unsigned BATTERY_BIT    = 7;
    localparam int unsigned MASK_LSB       = 0;
    localparam int unsigned FORCE_ON_BIT   = 0;
    localparam int unsigned FORCE_OFF_BIT  = 1;
    localparam int unsigned CLEAR_BIT      = 2;
    localparam int unsigned CODE_LSB       = 0;

    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    localparam logic [1:0] VMODE_EXT   = 2'h3;
    localparam logic [1:0] VMODE_BOOST = 2'h2;
    localparam logic [1:0] VMODE_DAC   = 2'h1;
    localparam logic [2:0] MUX_4_THIRD = 3'h0;
    localparam logic [2:0] MUX_3_THIRD = 3'h1;
    localparam logic [2:0] MUX_2_HALF  = 3'h2;
    localparam logic [2:0] MUX_3_HALF  = 3'h3;
    localparam logic [2:0] MUX_STATIC  = 3'h4;
    localparam logic [2:0] MUX_5_THIRD = 3'h5;
    localparam logic [2:0] MUX_6_THIRD = 3'h6;
    localparam int unsigned NUM_COMMONS = 6;
    localparam logic [1:0] LVL_GND = 2'h0; // ladder levels: ground, one third/half, two thirds, full
    localparam logic [1:0] LVL_1   = 2'h1;
    localparam logic [1:0] LVL_2   = 2'h2;
    localparam logic [1:0] LVL_TOP = 2'h3;

    // ------------------------------------------------------------
    // timing: slow clock 32768 Hz, frame divider 512 >> code
    // ------------------------------------------------------------
    localparam int unsigned SLOW_CLK_HZ    = 32768;
    localparam logic [8:0]  FRAME_CNT_MAX  = 9'h1ff;                   // divide by 512 at code 00
    localparam int unsigned BLINK_SLOW_BIT = $clog2(SLOW_CLK_HZ);      // 0.5 Hz: half period of one second
    localparam int unsigned BLINK_FAST_BIT = $clog2(SLOW_CLK_HZ / 2);  // 1 Hz: half period of half a second

    typedef enum logic [1:0] {BIAS_STATIC, BIAS_HALF, BIAS_THIRD} bias_t;

    typedef struct packed {
        logic [2:0] states;
        bias_t      bias;
    } mux_cfg_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } reg_bus_req_t;

    typedef struct packed {
        logic       external_supply_sel;
        logic       contrast_dac_en;
        logic       doubler_en;
        logic       dac_bypass;
        logic       dac_power_en;
        logic [4:0] contrast_code;
        logic       battery_supply_sel;
        logic       supply_from_battery;
        logic       supply_pin_drive_en;
    } supply_ctrl_t;

    typedef logic [5:0][1:0] com_levels_t;

endpackage

// >>> rtl/lcd_drive_control.sv
// Strobed register access is this design's own decision.
module lcd_drive_control
    import lcd_drive_pkg::*;
(
    // clock and reset
    input  wire logic                        clock_i,
    input  wire logic                        sys_rst_i,
    // register port
    input  wire lcd_drive_pkg::reg_bus_req_t bus_req_i,
    output logic [7:0]                       bus_rdata_o,
    // slow clock pin and context
    input  wire logic                        rtc_clk_i,
    input  wire logic                        brownout_power_mode_i,
    input  wire logic                        display_pin_map_26_i,
    input  wire logic                        display_pin_map_27_i,
    // supply control
    output lcd_drive_pkg::supply_ctrl_t      supply_ctrl_o,
    // waveform outputs
    output lcd_drive_pkg::com_levels_t       com_level_o,
    output logic                             bias_ground_o,
    output logic                             shared_pin_26_com_o,
    output logic                             shared_pin_27_com_o,
    // segment control
    output logic                             pixel_all_on_o,
    output logic                             pixel_all_off_o,
    output logic [5:0]                       blink_off_a_o,
    output logic [5:0]                       blink_off_b_o,
    output logic                             segment_data_clear_o
);
    import lcd_drive_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]             main_ctrl;        // display_main_control
        logic [7:0]             supply_blink_b;   // supply_mode_blink_mask_b
        logic [7:0]             battery_blink_a;  // battery_select_blink_mask_a
        logic [7:0]             override_ctrl;    // display_override_control
        logic [7:0]             contrast_dac;     // contrast_dac_setting
        logic [7:0]             rdata;            // read data, valid one cycle
        logic [1:0]             rtc_sync;         // two-flop synchroniser
        logic                   rtc_prev;         // edge detector history
        logic [BLINK_SLOW_BIT:0] tick_cnt;        // blink timebase
        logic [8:0]             frame_cnt;        // frame divider
        logic [2:0]             phase;            // current common phase
        logic                   invert;           // second half of the AC frame
        supply_ctrl_t           supply;
        com_levels_t            com_level;
        logic                   bias_ground;
        logic                   sp26_com;
        logic                   sp27_com;
        logic                   all_on;
        logic                   all_off;
        logic [5:0]             blink_a;
        logic [5:0]             blink_b;
        logic                   clear_pulse;
    } state_t;

    state_t st_reg;  // registered state
    state_t st_next; // next state

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic mux_cfg_t decode_mux(input logic [2:0] m);
        mux_cfg_t c;
        c.states = 3'h4;
        c.bias   = BIAS_THIRD;
        case (m)
            MUX_4_THIRD: c = '{states: 3'h4, bias: BIAS_THIRD};
            MUX_3_THIRD: c = '{states: 3'h3, bias: BIAS_THIRD};
            MUX_2_HALF:  c = '{states: 3'h2, bias: BIAS_HALF};
            MUX_3_HALF:  c = '{states: 3'h3, bias: BIAS_HALF};
            MUX_STATIC:  c = '{states: 3'h1, bias: BIAS_STATIC};
            MUX_5_THIRD: c = '{states: 3'h5, bias: BIAS_THIRD};
            MUX_6_THIRD: c = '{states: 3'h6, bias: BIAS_THIRD};
            default:     c = '{states: 3'h4, bias: BIAS_THIRD}; // unused code behaves as the reset mode
        endcase
        return c;
    endfunction

    logic       display_en;   // display enable bit
    logic [2:0] mux_code;     // multiplex field
    logic [1:0] vmode;        // supply mode field
    logic [4:0] code;         // contrast code
    logic [8:0] frame_limit;  // divider terminal count
    logic       slow_tick;    // one cycle per slow clock rising edge
    logic       frame_tick;   // one cycle per frame period
    logic       blink_phase;  // high in the off half of the blink period
    mux_cfg_t   cfg;          // decoded multiplex mode
    logic [2:0] last_phase;   // final phase index of the mode

    assign display_en  = st_reg.main_ctrl[ENABLE_BIT];
    assign mux_code    = st_reg.main_ctrl[MUX_LSB +: 3];
    assign vmode       = st_reg.supply_blink_b[VMODE_LSB +: 2];
    assign code        = st_reg.contrast_dac[CODE_LSB +: 5];
    assign cfg         = decode_mux(mux_code);
    assign last_phase  = cfg.states - 3'h1;
    // only the second flop and its history feed the edge detector
    assign slow_tick   = st_reg.rtc_sync[1] & ~st_reg.rtc_prev;
    assign frame_limit = FRAME_CNT_MAX >> st_reg.main_ctrl[CLKDIV_LSB +: 2];
    assign frame_tick  = slow_tick && (st_reg.frame_cnt >= frame_limit);
    assign blink_phase = st_reg.main_ctrl[BLINK_RATE_BIT] ? st_reg.tick_cnt[BLINK_FAST_BIT]
                                                           : st_reg.tick_cnt[BLINK_SLOW_BIT];

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_next             = st_reg;
        st_next.clear_pulse = 1'b0;
        st_next.rdata       = '0;
        st_next.rtc_sync    = {st_reg.rtc_sync[0], rtc_clk_i};
        st_next.rtc_prev    = st_reg.rtc_sync[1];

        // register writes; reserved bits are dropped so they read zero
        if (bus_req_i.wr) begin
            if (bus_req_i.addr == MAIN_CTRL_ADDR) begin
                st_next.main_ctrl = bus_req_i.wdata;
            end else if (bus_req_i.addr == SUPPLY_BLINK_B_ADDR) begin
                st_next.supply_blink_b = bus_req_i.wdata;
            end else if (bus_req_i.addr == BATTERY_BLINK_A_ADDR) begin
                st_next.battery_blink_a = bus_req_i.wdata & BATTERY_MASK;
            end else if (bus_req_i.addr == OVERRIDE_CTRL_ADDR) begin
                st_next.override_ctrl = bus_req_i.wdata & OVERRIDE_MASK;
                st_next.clear_pulse   = bus_req_i.wdata[CLEAR_BIT];
            end else if (bus_req_i.addr == CONTRAST_DAC_ADDR) begin
                st_next.contrast_dac = bus_req_i.wdata & CONTRAST_MASK;
            end
        end

        // register reads; unmapped addresses answer zero
        if (bus_req_i.rd) begin
            if (bus_req_i.addr == MAIN_CTRL_ADDR) begin
                st_next.rdata = st_reg.main_ctrl;
            end else if (bus_req_i.addr == SUPPLY_BLINK_B_ADDR) begin
                st_next.rdata = st_reg.supply_blink_b;
            end else if (bus_req_i.addr == BATTERY_BLINK_A_ADDR) begin
                st_next.rdata = st_reg.battery_blink_a;
            end else if (bus_req_i.addr == OVERRIDE_CTRL_ADDR) begin
                st_next.rdata = st_reg.override_ctrl;
            end else if (bus_req_i.addr == CONTRAST_DAC_ADDR) begin
                st_next.rdata = st_reg.contrast_dac;
            end else if (bus_req_i.addr == SEQ_STATUS_ADDR) begin
                st_next.rdata = {3'h0, blink_phase, st_reg.invert, st_reg.phase};
            end
        end

        // timebases run on slow clock edges only
        if (slow_tick) begin
            st_next.tick_cnt  = st_reg.tick_cnt + 1'b1;
            st_next.frame_cnt = frame_tick ? 9'h000 : st_reg.frame_cnt + 9'h001;
        end

        // one phase per frame; >= also recovers when the mode shrinks
        if (frame_tick) begin
            if (st_reg.phase >= last_phase) begin
                st_next.phase  = 3'h0;
                st_next.invert = ~st_reg.invert;
            end else begin
                st_next.phase = st_reg.phase + 3'h1;
            end
        end

        // supply decode; doubler is not qualified by power mode
        st_next.supply.external_supply_sel = (vmode == VMODE_EXT);
        st_next.supply.contrast_dac_en     = (vmode == VMODE_BOOST) || (vmode == VMODE_DAC);
        st_next.supply.doubler_en          = (vmode == VMODE_BOOST);
        st_next.supply.dac_bypass          = (code == 5'h00);
        // external supply makes the contrast setting meaningless
        st_next.supply.dac_power_en        = st_next.supply.contrast_dac_en && (code != 5'h00)
                                             && !st_next.supply.external_supply_sel;
        st_next.supply.contrast_code       = code;
        st_next.supply.battery_supply_sel  = st_reg.battery_blink_a[BATTERY_BIT];
        st_next.supply.supply_from_battery = st_reg.battery_blink_a[BATTERY_BIT] | brownout_power_mode_i;
        st_next.supply.supply_pin_drive_en = !st_next.supply.external_supply_sel;

        // shared pins become commons
        st_next.sp27_com = (mux_code == MUX_5_THIRD) || (mux_code == MUX_6_THIRD)
                           || (st_reg.main_ctrl[ALLCOM_BIT] && display_pin_map_27_i);
        st_next.sp26_com = (mux_code == MUX_6_THIRD)
                           || (st_reg.main_ctrl[ALLCOM_BIT] && display_pin_map_26_i);

        // common waveforms per phase and AC half
        for (int i = 0; i < NUM_COMMONS; i++) begin
            if (!display_en) begin
                st_next.com_level[i] = LVL_GND;
            end else if (3'(i) < cfg.states) begin
                if (st_reg.phase == 3'(i)) begin
                    st_next.com_level[i] = st_reg.invert ? LVL_GND : LVL_TOP;
                end else if (cfg.bias == BIAS_THIRD) begin
                    st_next.com_level[i] = st_reg.invert ? LVL_2 : LVL_1;
                end else begin
                    st_next.com_level[i] = LVL_1;
                end
            end else begin
                // unused common follows the segment-off waveform, so its pixels see no net voltage
                case (cfg.bias)
                    BIAS_THIRD: st_next.com_level[i] = st_reg.invert ? LVL_1 : LVL_2;
                    BIAS_HALF:  st_next.com_level[i] = LVL_1;
                    default:    st_next.com_level[i] = st_reg.invert ? LVL_GND : LVL_TOP;
                endcase
            end
        end
        st_next.bias_ground = !display_en;

        // overrides never touch stored data; force on wins over blank
        st_next.all_on  = st_reg.override_ctrl[FORCE_ON_BIT];
        st_next.all_off = st_reg.override_ctrl[FORCE_OFF_BIT] && !st_reg.override_ctrl[FORCE_ON_BIT];

        // blinking pixels are forced off during the off half
        st_next.blink_a = st_reg.battery_blink_a[MASK_LSB +: 6] & {6{blink_phase}};
        st_next.blink_b = st_reg.supply_blink_b[MASK_LSB +: 6] & {6{blink_phase}};
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // blink masks are reset only by this reset, never by a power-mode change
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            st_reg                 <= '0;
            st_reg.main_ctrl       <= REG_RESET;
            st_reg.supply_blink_b  <= REG_RESET;
            st_reg.battery_blink_a <= REG_RESET;
            st_reg.override_ctrl   <= REG_RESET;
            st_reg.contrast_dac    <= REG_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus_rdata_o          = st_reg.rdata;
    assign supply_ctrl_o        = st_reg.supply;
    assign com_level_o          = st_reg.com_level;
    assign bias_ground_o        = st_reg.bias_ground;
    assign shared_pin_26_com_o  = st_reg.sp26_com;
    assign shared_pin_27_com_o  = st_reg.sp27_com;
    assign pixel_all_on_o       = st_reg.all_on;
    assign pixel_all_off_o      = st_reg.all_off;
    assign blink_off_a_o        = st_reg.blink_a;
    assign blink_off_b_o        = st_reg.blink_b;
    assign segment_data_clear_o = st_reg.clear_pulse;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    property p_vmode_ext;
        vmode == VMODE_EXT |=> supply_ctrl_o.external_supply_sel && !supply_ctrl_o.contrast_dac_en
                               && !supply_ctrl_o.doubler_en;
    endproperty
    a_vmode_ext: assert property (p_vmode_ext) else $error("external mode decode wrong");

    property p_vmode_boost;
        vmode == VMODE_BOOST |=> supply_ctrl_o.contrast_dac_en && supply_ctrl_o.doubler_en
                                 && !supply_ctrl_o.external_supply_sel;
    endproperty
    a_vmode_boost: assert property (p_vmode_boost) else $error("boost mode decode wrong");

    property p_dac_zero;
        code == 5'h00 |=> supply_ctrl_o.dac_bypass && !supply_ctrl_o.dac_power_en;
    endproperty
    a_dac_zero: assert property (p_dac_zero) else $error("zero contrast code not bypassed");

    property p_ext_no_drive;
        supply_ctrl_o.external_supply_sel |-> !supply_ctrl_o.supply_pin_drive_en && !supply_ctrl_o.dac_power_en;
    endproperty
    a_ext_no_drive: assert property (p_ext_no_drive) else $error("supply pin driven in external mode");

    property p_disabled_ground;
        !display_en |=> bias_ground_o && (com_level_o == '0);
    endproperty
    a_disabled_ground: assert property (p_disabled_ground) else $error("disabled display not grounded");

    property p_force_on_wins;
        st_reg.override_ctrl[FORCE_ON_BIT] |=> pixel_all_on_o && !pixel_all_off_o;
    endproperty
    a_force_on_wins: assert property (p_force_on_wins) else $error("force on does not win");

    property p_clear_pulse;
        bus_req_i.wr && bus_req_i.addr == OVERRIDE_CTRL_ADDR && bus_req_i.wdata[CLEAR_BIT]
            |=> segment_data_clear_o;
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse missing");

    property p_phase_wrap;
        frame_tick && st_reg.phase >= last_phase |=> st_reg.phase == 3'h0 && st_reg.invert != $past(st_reg.invert);
    endproperty
    a_phase_wrap: assert property (p_phase_wrap) else $error("phase did not wrap");

    property p_six_commons;
        mux_code == MUX_6_THIRD |=> shared_pin_26_com_o && shared_pin_27_com_o;
    endproperty
    a_six_commons: assert property (p_six_commons) else $error("six-state mode lacks commons");

    property p_unused_common;
        display_en && mux_code == MUX_2_HALF |=> com_level_o[2] == LVL_1 && com_level_o[5] == LVL_1;
    endproperty
    a_unused_common: assert property (p_unused_common) else $error("unused common not at off level");

    // doubler follows the decode even while running from the battery
    property p_doubler_any_mode;
        vmode == VMODE_BOOST && brownout_power_mode_i |=> supply_ctrl_o.doubler_en;
    endproperty
    a_doubler_any_mode: assert property (p_doubler_any_mode) else $error("doubler dropped in battery mode");

    // all-common leaves an unmapped shared pin alone outside five/six-state modes
    property p_allcom_map;
        st_reg.main_ctrl[ALLCOM_BIT] && !display_pin_map_27_i && mux_code != MUX_5_THIRD
            && mux_code != MUX_6_THIRD |=> !shared_pin_27_com_o;
    endproperty
    a_allcom_map: assert property (p_allcom_map) else $error("unmapped shared pin became a common");

    // blank alone turns every pixel off
    property p_force_off;
        st_reg.override_ctrl[FORCE_OFF_BIT] && !st_reg.override_ctrl[FORCE_ON_BIT] |=> pixel_all_off_o;
    endproperty
    a_force_off: assert property (p_force_off) else $error("blank does not turn pixels off");

    c_boost:     cover property (vmode == VMODE_BOOST && code != 5'h00);
    c_six_wrap:  cover property (mux_code == MUX_6_THIRD && frame_tick && st_reg.phase == 3'h5);
    c_blink:     cover property (blink_off_a_o != 6'h00);
    c_force_all: cover property (pixel_all_on_o && st_reg.override_ctrl[FORCE_OFF_BIT]);

endmodule

// >>> verif/glass_model.sv
// ----------------------------------------
// slow reference clock seen by the glass
// ----------------------------------------
module glass_model (
    // run control
    input  wire logic run_i,
    // slow clock towards the block
    output logic      rtc_clk_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // sped-up slow clock; stands still low while not running
    initial begin
        rtc_clk_o = 1'b0;
        forever begin
            #20 rtc_clk_o = run_i ? ~rtc_clk_o : 1'b0;
        end
    end
endmodule

// >>> verif/test_lcd_drive_control.sv
// ----------------------------------------
// register-level bench for the display control
// ----------------------------------------
module test_lcd_drive_control;
    timeunit 1ns;
    timeprecision 1ps;
    import lcd_drive_pkg::*;
    logic clock_i, sys_rst_i, rtc_clk, brown, map26, map27, run;
    reg_bus_req_t req;
    logic [7:0] rdata;
    supply_ctrl_t sup;
    logic g, s26, s27, on, off, clr;
    int failures, checks;
    com_levels_t com;
    logic [5:0] ba, bb;
    logic [7:0] st0, st1;
    int n;
    glass_model glass_u (.run_i(run), .rtc_clk_o(rtc_clk));
    lcd_drive_control dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus_req_i(req), .bus_rdata_o(rdata),
        .rtc_clk_i(rtc_clk), .brownout_power_mode_i(brown), .display_pin_map_26_i(map26),
        .display_pin_map_27_i(map27), .supply_ctrl_o(sup), .com_level_o(com), .bias_ground_o(g),
        .shared_pin_26_com_o(s26), .shared_pin_27_com_o(s27), .pixel_all_on_o(on), .pixel_all_off_o(off),
        .blink_off_a_o(ba), .blink_off_b_o(bb), .segment_data_clear_o(clr));
    // clock, 4 ns period
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe; derived outputs are settled two edges later
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_i) req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock_i) req <= '{a, d, 1'b0, 1'b0};
        @(posedge clock_i);
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clock_i) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock_i) req <= '{a, 8'h00, 1'b0, 1'b0};
        #1 chk(rdata, exp);
    endtask
    // same read, handing the data back instead of comparing
    task automatic rd_get(input logic [15:0] a, output logic [7:0] d);
        @(posedge clock_i) req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock_i) req <= '{a, 8'h00, 1'b0, 1'b0};
        #1 d = rdata;
    endtask
    task automatic wrap_up();
        if (failures == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // bound on the whole run
    initial begin
        #200000 failures++;
        wrap_up();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        req = '0; sys_rst_i = 1'b1; brown = 1'b0; map26 = 1'b0; map27 = 1'b0; run = 1'b1;
        repeat (20) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        // reset values, then masked read-back and an unmapped place
        rd(16'h2400, 8'h00);
        rd(16'h2402, 8'h00);
        wr(16'h2400, 8'hff); rd(16'h2400, 8'hff);
        wr(16'h2402, 8'hff); rd(16'h2402, 8'hbf);
        wr(16'h240c, 8'hff); rd(16'h240c, 8'h03);
        wr(16'h240d, 8'hff); rd(16'h240d, 8'h1f);
        wr(16'h2403, 8'h5a); rd(16'h2403, 8'h00);
        // battery route and contrast code
        chk({7'h0, sup.supply_from_battery}, 8'h01);
        chk({2'h0, sup.dac_bypass, sup.contrast_code}, 8'h1f);
        wr(16'h240d, 8'h00);
        chk({6'h0, sup.dac_bypass, sup.dac_power_en}, 8'h02);
        wr(16'h2402, 8'h00); brown <= 1'b1; wr(16'h2402, 8'h00);
        chk({7'h0, sup.supply_from_battery}, 8'h01);
        wr(16'h2401, 8'h80);
        chk({7'h0, sup.doubler_en}, 8'h01);
        brown <= 1'b0;
        // every supply mode decode
        for (int m = 0; m < 4; m++) begin
            wr(16'h2401, 8'(m << 6));
            chk({4'h0, sup.external_supply_sel, sup.contrast_dac_en, sup.doubler_en, sup.supply_pin_drive_en},
                {4'h0, m == 3, m == 1 || m == 2, m == 2, m != 3});
        end
        // every multiplex code and its shared commons
        for (int k = 0; k < 7; k++) begin
            wr(16'h2400, 8'h80 | 8'(k << 4));
            chk({6'h0, s26, s27}, {6'h0, k == 6, k >= 5});
        end
        map27 <= 1'b1;
        wr(16'h2400, 8'h88);
        chk({6'h0, s26, s27}, 8'h01);
        chk({7'h0, g}, 8'h00);
        wr(16'h2400, 8'h00);
        chk({7'h0, g}, 8'h01);
        chk(com[3:0], 8'h00);
        chk({4'h0, com[5:4]}, 8'h00);
        // two states at half bias: commons 2..5 sit at the off level
        wr(16'h2400, 8'ha0);
        chk({com[5], com[4], com[3], com[2]}, 8'h55);
        // blink masks set, still in the on half of the blink period
        wr(16'h2402, 8'h3f); wr(16'h2401, 8'h3f);
        chk({2'h0, ba}, 8'h00);
        chk({2'h0, bb}, 8'h00);
        // divide by 64: one phase step per 64 slow ticks of ten clocks
        wr(16'h2400, 8'h83);
        rd_get(16'h2410, st0);
        n = 0;
        do begin
            rd_get(16'h2410, st1);
            n++;
        end while (st1[2:0] == st0[2:0] && n < 400);
        st0 = st1;
        n = 0;
        do begin
            rd_get(16'h2410, st1);
            n++;
        end while (st1[2:0] == st0[2:0] && n < 400);
        chk({7'h0, n >= 318 && n <= 322}, 8'h01);
        chk({5'h0, st1[2:0]}, {5'h0, (st0[2:0] == 3'h3) ? 3'h0 : st0[2:0] + 3'h1});
        chk({6'h0, com[st1[2:0]]}, {6'h0, st1[3] ? LVL_GND : LVL_TOP});
        // overrides and the clear pulse
        wr(16'h240c, 8'h02); chk({6'h0, on, off}, 8'h01);
        wr(16'h240c, 8'h03); chk({6'h0, on, off}, 8'h02);
        @(posedge clock_i) req <= '{16'h240c, 8'h04, 1'b1, 1'b0};
        @(posedge clock_i) req <= '{16'h240c, 8'h04, 1'b0, 1'b0};
        #1 chk({7'h0, clr}, 8'h01);
        @(posedge clock_i) #1 chk({7'h0, clr}, 8'h00);
        wrap_up();
    end
endmodule
